// File: hdl/fc_phy.sv
// Purpose: Transceiver end holding the function control register and its side effects.
// Assumes: Link keeps off the bus while dir is high.
// Notes:   Reads at any alias return the register one cycle later.
`timescale 1ns/1ns
`default_nettype none
module fc_phy #(
  parameter int unsigned RESET_CYCLES = fc_pkg::CORE_RESET_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  fc_link_if.phy    bus,
  input  wire logic plus_line_pd_ctrl,
  input  wire logic minus_line_pd_ctrl,
  output logic      low_power_q,
  output logic      core_reset_q,
  output logic      hs_xcvr_en_q,
  output logic      fs_xcvr_en_q,
  output logic      ls_xcvr_en_q,
  output logic      preamble_en_q,
  output logic      fs_pullup_en_q,
  output logic      hs_term_en_q,
  output logic      bit_stuff_en_q,
  output logic      sync_eop_en_q,
  output logic      tx_drive_en_q
);
  import fc_pkg::*;

  logic [7:0] func_q;
  logic [7:0] func_d;
  logic [3:0] rst_cnt_q;
  logic       wake;
  logic       reset_done;
  logic       in_range;
  enc_t       enc;
  speed_t     spd;

  // ----------------------------------------------------------------
  // Register aliases
  // ----------------------------------------------------------------
  assign enc        = enc_t'(func_q[ENC_LSB +: 2]);
  assign spd        = speed_t'(func_q[SPEED_LSB +: 2]);
  assign wake       = low_power_q && bus.stp;
  assign reset_done = core_reset_q && (rst_cnt_q == 4'(RESET_CYCLES - 1));
  // Any other address reads as zero, so a stray read never shows stale
  // contents of this register.
  assign in_range   = (bus.addr >= ADDR_WRITE) && (bus.addr <= ADDR_CLEAR);

  always_comb begin
    func_d = func_q;
    if (bus.wr) begin
      if (bus.addr == ADDR_WRITE) begin
        func_d = bus.wdata & FUNC_WRITE_MASK;
      end else if (bus.addr == ADDR_SET) begin
        func_d = func_q | (bus.wdata & FUNC_WRITE_MASK);
      end else if (bus.addr == ADDR_CLEAR) begin
        func_d = func_q & ~bus.wdata;
      end
    end
    // Waking is read as returning the bit to powered; it overrides a write
    // in the same cycle so that the device cannot fall straight back asleep.
    // wake restores powered
    if (wake) begin
      func_d[BIT_LOW_POWER_N] = 1'b1;
    end
    if (reset_done) begin
      func_d[BIT_CORE_RESET] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      func_q <= FUNC_RESET_VAL;
    end else begin
      func_q <= func_d;
    end
  end

  // Read data stays until the next read, which lets the link pick it up
  // one cycle later without a valid flag.
  // read any alias
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.rdata <= 8'h00;
    end else if (bus.rd) begin
      bus.rdata <= in_range ? func_q : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Transceiver reset sequence
  // ----------------------------------------------------------------
  // The counter runs only while the core is held in reset, so dir stands
  // for exactly RESET_CYCLES cycles; the register itself is never touched
  // here apart from the self-clearing bit.
  // dir and core reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_reset_q <= 1'b0;
      rst_cnt_q    <= 4'h0;
    end else if (reset_done) begin
      core_reset_q <= 1'b0;
      rst_cnt_q    <= 4'h0;
    end else if (func_q[BIT_CORE_RESET]) begin
      core_reset_q <= 1'b1;
      rst_cnt_q    <= core_reset_q ? rst_cnt_q + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.dir   <= 1'b0;
      bus.rxcmd <= 1'b0;
    end else begin
      bus.dir   <= func_q[BIT_CORE_RESET] && !reset_done;
      bus.rxcmd <= reset_done;
    end
  end

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  // Each control follows the register one cycle late, or two where gated by low_power_q,
  // so that every output of this end comes straight from a flip-flop.

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_power_q <= 1'b0;
    end else begin
      low_power_q <= !func_q[BIT_LOW_POWER_N];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hs_xcvr_en_q  <= 1'b0;
      fs_xcvr_en_q  <= 1'b0;
      ls_xcvr_en_q  <= 1'b0;
      preamble_en_q <= 1'b0;
    end else begin
      hs_xcvr_en_q  <= !low_power_q && spd == SPD_HIGH;
      // The full-speed receiver stays up in low power, so it is not gated.
      // full speed for preamble
      fs_xcvr_en_q  <= spd == SPD_FULL || spd == SPD_LOW_PRE;
      ls_xcvr_en_q  <= !low_power_q && spd == SPD_LOW;
      preamble_en_q <= !low_power_q && spd == SPD_LOW_PRE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fs_pullup_en_q <= 1'b0;
      hs_term_en_q   <= 1'b0;
    end else begin
      // This is a simplified view of the resistor table; the pull-down
      // controls only veto the terminations here.
      fs_pullup_en_q <= func_q[BIT_TERM] && spd != SPD_HIGH && enc != ENC_NON_DRIVE
                        && !plus_line_pd_ctrl;
      hs_term_en_q   <= !func_q[BIT_TERM] && spd == SPD_HIGH && !low_power_q
                        && !(plus_line_pd_ctrl && minus_line_pd_ctrl && enc == ENC_NON_DRIVE);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bit_stuff_en_q <= 1'b0;
      sync_eop_en_q  <= 1'b0;
      tx_drive_en_q  <= 1'b0;
    end else begin
      bit_stuff_en_q <= enc != ENC_RAW;
      sync_eop_en_q  <= enc != ENC_NO_SYNC;
      tx_drive_en_q  <= enc != ENC_NON_DRIVE && !low_power_q;
    end
  end
endmodule
`default_nettype wire

// File: hdl/fc_pkg.sv
// Purpose: Shared constants for the transceiver function control register and its link.
// Assumes: One clock at 20 MHz; register accesses are single-cycle requests.
// Notes:   Field positions, aliases and reset values live here only.
`default_nettype none
package fc_pkg;
  localparam logic [5:0] ADDR_WRITE = 6'h04;
  localparam logic [5:0] ADDR_SET   = 6'h05;
  localparam logic [5:0] ADDR_CLEAR = 6'h06;
  localparam int unsigned BIT_LOW_POWER_N = 6;
  localparam int unsigned BIT_CORE_RESET  = 5;
  localparam int unsigned ENC_LSB         = 3;
  localparam int unsigned BIT_TERM        = 2;
  localparam int unsigned SPEED_LSB       = 0;
  localparam logic [7:0] FUNC_RESET_VAL  = 8'h41;
  localparam logic [7:0] FUNC_WRITE_MASK = 8'h7f;
  localparam int unsigned CORE_RESET_CYCLES = 8;
  typedef enum logic [1:0] {
    ENC_NORMAL    = 2'b00,
    ENC_NON_DRIVE = 2'b01,
    ENC_RAW       = 2'b10,
    ENC_NO_SYNC   = 2'b11
  } enc_t;
  typedef enum logic [1:0] {
    SPD_HIGH     = 2'b00,
    SPD_FULL     = 2'b01,
    SPD_LOW      = 2'b10,
    SPD_LOW_PRE  = 2'b11
  } speed_t;
  typedef enum logic [1:0] {
    CMD_NONE  = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_SET   = 2'b10,
    CMD_CLEAR = 2'b11
  } cmd_t;
endpackage
`default_nettype wire

// File: hdl/fc_link_if.sv
// Purpose: Carrier between the link controller and the transceiver register end.
// Assumes: Both ends run on the same clock.
// Notes:   The register access is abstracted to address, data and strobes.
`timescale 1ns/1ns
`default_nettype none
interface fc_link_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       dir;
  logic       stp;
  logic       rxcmd;
  modport phy  (input addr, wdata, wr, rd, stp, output rdata, dir, rxcmd);
  modport link (output addr, wdata, wr, rd, stp, input rdata, dir, rxcmd);
endinterface
`default_nettype wire

// File: hdl/fc_link.sv
// Purpose: Link controller end that drives the function control register.
// Assumes: User commands arrive as single-cycle requests on a plain port.
// Notes:   Commands are refused while dir is high after a transceiver reset.
`timescale 1ns/1ns
`default_nettype none
module fc_link (
  input  wire logic         clk,
  input  wire logic         reset,
  fc_link_if.link           bus,
  input  wire fc_pkg::cmd_t cmd,
  input  wire logic [7:0]   cmd_data,
  input  wire logic         cmd_rd,
  input  wire logic         wake_req,
  output logic [7:0]        rd_data_q,
  output logic              busy_q,
  output logic              status_seen_q
);
  import fc_pkg::*;

  logic rd_pend_q;
  logic wait_q;

  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.addr  <= 6'h00;
      bus.wdata <= 8'h00;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.stp   <= 1'b0;
    end else begin
      bus.wr  <= 1'b0;
      bus.rd  <= 1'b0;
      bus.stp <= wake_req;
      if (!bus.dir && !wait_q) begin
        if (cmd != CMD_NONE) begin
          bus.wr    <= 1'b1;
          bus.wdata <= cmd_data;
          bus.addr  <= (cmd == CMD_WRITE) ? ADDR_WRITE :
                       (cmd == CMD_SET) ? ADDR_SET : ADDR_CLEAR;
        end else if (cmd_rd) begin
          bus.rd   <= 1'b1;
          bus.addr <= ADDR_WRITE;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b0;
    end else if (bus.wr && bus.wdata[BIT_CORE_RESET] && bus.addr != ADDR_CLEAR) begin
      wait_q <= 1'b1;
    end else if (bus.rxcmd) begin
      wait_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_pend_q     <= 1'b0;
      rd_data_q     <= 8'h00;
      busy_q        <= 1'b0;
      status_seen_q <= 1'b0;
    end else begin
      rd_pend_q     <= bus.rd;
      busy_q        <= bus.dir || wait_q;
      status_seen_q <= bus.rxcmd;
      if (rd_pend_q) begin
        rd_data_q <= bus.rdata;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/fc_assertions.sv
// Purpose: Bus checks between the link end and the transceiver end.
// Assumes: One clock; reset asynchronous, active high.
// Notes:   A shadow copy of the register predicts reads at the aliases while dir and stp are low.
`timescale 1ns/1ns
`default_nettype none
module fc_assertions #(
  parameter int unsigned RESET_CYCLES = 8
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       dir,
  input wire logic       stp,
  input wire logic       rxcmd
);
  import fc_pkg::*;
  logic [7:0] shadow_q;
  logic [4:0] dir_cnt_q;
  // ----------------------------------
  // Shadow register and dir length
  // ----------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) shadow_q <= FUNC_RESET_VAL;
    else if (wr && addr == ADDR_WRITE) shadow_q <= wdata & FUNC_WRITE_MASK;
    else if (wr && addr == ADDR_SET) shadow_q <= shadow_q | (wdata & FUNC_WRITE_MASK);
    else if (wr && addr == ADDR_CLEAR) shadow_q <= shadow_q & ~wdata;
    else if (rxcmd) shadow_q[BIT_CORE_RESET] <= 1'b0;
    else if (stp) shadow_q[BIT_LOW_POWER_N] <= 1'b1;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) dir_cnt_q <= 5'h0;
    else dir_cnt_q <= dir ? dir_cnt_q + 5'h1 : 5'h0;
  end
  // ----------------------------------
  // Properties
  // ----------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_alias_read: assert property (
    rd && addr >= ADDR_WRITE && addr <= ADDR_CLEAR && !dir && !stp |=> rdata == $past(shadow_q))
    else $error("read value differs from shadow");
  a_bit7_zero: assert property (rd |=> !rdata[7]) else $error("bit 7 read high");
  a_reset_dir: assert property (
    wr && addr != ADDR_CLEAR && wdata[BIT_CORE_RESET] |-> ##[1:2] dir)
    else $error("dir missing after reset write");
  a_dir_cause: assert property (
    $rose(dir) |-> $past(wr && wdata[BIT_CORE_RESET]) || $past(wr && wdata[BIT_CORE_RESET], 2))
    else $error("dir rose without reset write");
  a_dir_length: assert property (
    $fell(dir) |-> dir_cnt_q >= RESET_CYCLES && dir_cnt_q <= RESET_CYCLES + 1)
    else $error("dir held for wrong length");
  a_rxcmd_end: assert property ($fell(dir) == rxcmd) else $error("status not at reset end");
  a_rxcmd_pulse: assert property (rxcmd |=> !rxcmd) else $error("status longer than one cycle");
  a_bus_quiet: assert property (dir |-> !wr && !rd) else $error("bus used while dir high");
endmodule
`default_nettype wire

// File: verif/ulpi_function_control_reg_tb.sv
// Purpose: Drives both ends through the link user port and checks results.
// Assumes: Short core reset so the run stays brief.
// Notes:   Reads wait a fixed gap since the link answers two cycles after the bus.
`timescale 1ns/1ns
`default_nettype none
module ulpi_function_control_reg_tb;
  import fc_pkg::*;
  logic       clk, reset, cmd_rd, wake_req, lp, crst, hs, fs, ls, pre, stf, syn, drv, busy, pu, ht;
  cmd_t       cmd;
  logic [7:0] cmd_data, rd_data;
  int         n_errors = 0;
  int         num_checks = 0;
  fc_link_if fc_link_if_i ();
  fc_phy #(.RESET_CYCLES(4)) fc_phy_i (.clk(clk), .reset(reset), .bus(fc_link_if_i.phy),
    .plus_line_pd_ctrl(1'b0), .minus_line_pd_ctrl(1'b1), .low_power_q(lp), .core_reset_q(crst),
    .hs_xcvr_en_q(hs), .fs_xcvr_en_q(fs), .ls_xcvr_en_q(ls), .preamble_en_q(pre),
    .fs_pullup_en_q(pu), .hs_term_en_q(ht), .bit_stuff_en_q(stf), .sync_eop_en_q(syn),
    .tx_drive_en_q(drv));
  fc_link fc_link_i (.clk(clk), .reset(reset), .bus(fc_link_if_i.link), .cmd(cmd),
    .cmd_data(cmd_data), .cmd_rd(cmd_rd), .wake_req(wake_req), .rd_data_q(rd_data),
    .busy_q(busy), .status_seen_q());
  fc_assertions #(.RESET_CYCLES(4)) fc_assertions_i (.clk(clk), .reset(reset),
    .addr(fc_link_if_i.addr), .wdata(fc_link_if_i.wdata), .wr(fc_link_if_i.wr),
    .rd(fc_link_if_i.rd), .rdata(fc_link_if_i.rdata), .dir(fc_link_if_i.dir),
    .stp(fc_link_if_i.stp), .rxcmd(fc_link_if_i.rxcmd));
  // ----------------------------------
  // Tasks
  // ----------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // The link drops commands while busy, so every wait is bounded.
  task automatic wait_idle();
    int i;
    i = 0;
    repeat (4) @(posedge clk);
    while (busy !== 1'b0 && i < 50) begin
      @(posedge clk);
      i++;
    end
    if (i == 50) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic issue(input cmd_t c, input logic [7:0] d);
    @(posedge clk);
    cmd <= c;
    cmd_data <= d;
    @(posedge clk);
    cmd <= CMD_NONE;
  endtask
  task automatic op(input cmd_t c, input logic [7:0] d);
    issue(c, d);
    wait_idle();
  endtask
  task automatic read_chk(input logic [7:0] exp);
    @(posedge clk);
    cmd_rd <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    repeat (4) @(posedge clk);
    check(rd_data, exp);
  endtask
  // ----------------------------------
  // Stimulus
  // ----------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    cmd = CMD_NONE;
    cmd_data = 8'h00;
    cmd_rd = 1'b0;
    wake_req = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    read_chk(8'h41);
    check({6'h0, lp, fs}, 8'h01);
    op(CMD_WRITE, 8'h9a);
    read_chk(8'h1a);
    check({7'h0, lp}, 8'h01);
    op(CMD_SET, 8'h44);
    read_chk(8'h5e);
    check({6'h0, pu, ht}, 8'h02);
    op(CMD_CLEAR, 8'h18);
    read_chk(8'h46);
    // no packets are sent while mode 01 is set here.
    for (int i = 0; i < 4; i++) begin
      op(CMD_WRITE, 8'h40 | 8'(i * 9));
      check({7'h0, ht}, {7'h0, i == 0});
      check({4'h0, hs, fs, ls, pre}, {4'h0, i == 0, i[0], i == 2, i == 3});
      check({5'h0, stf, syn, drv}, {5'h0, i != 2, i != 3, i != 1});
    end
    issue(CMD_SET, 8'h20);
    repeat (3) @(negedge clk);
    check({7'h0, crst}, 8'h01);
    issue(CMD_CLEAR, 8'hff);
    wait_idle();
    read_chk(8'h5b);
    op(CMD_WRITE, 8'h01);
    check({7'h0, lp}, 8'h01);
    wake_req <= 1'b1;
    repeat (4) @(posedge clk);
    wake_req <= 1'b0;
    repeat (4) @(posedge clk);
    read_chk(8'h41);
    check({7'h0, lp}, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
